// file: core/csei_pkg.sv
// Constants shared by the card socket event interrupt logic.
// Assumes a single 10 MHz reference clock and a simple register access port.
// Functional notes
// - Memory card: any change on either battery pin is a status-change event.
// - Battery events set legacy flags 1 and 0, gated by legacy enables 1 and 0.
// - Memory card ready pin change sets legacy flag 2, gated by enable 2.
// - I/O card status-change assertion sets legacy flag 0, gated by enable 0.
// - 16-bit card power cycle completion sets legacy flag 3, gated by enable 3.
// - Functional requests are never masked; pending state reads in config 91h bit 0.
// - CardBus status-change assertion sets socket event bit 0, gated by mask 0.
// - CardBus power-up completion sets socket event bit 3, gated by mask 3.
// - Card-detect pin A changing sets socket event bit 1; pin B changing sets bit 2.
// - Insertion and removal are reported for every card type.
// - With a memory card the ready pin is never a functional request.
// - Shared pins are read according to the inserted card type.
// - Host interrupt levels leave through the seven multifunction pins, or to the serializer for serial requests.
// - PCI pin line works alongside parallel or serialized legacy signalling.
// - Legacy flags clear on read or write-one; global control bit 2 selects.
// - CardBus event flags clear when software writes one to them.
package csei_pkg;
  typedef enum logic [1:0] {
    CSEI_CARD_NONE,
    CSEI_CARD_MEMORY,
    CSEI_CARD_IO,
    CSEI_CARD_CARDBUS
  } csei_card_t;

  typedef enum logic [1:0] {
    CSEI_SPACE_LEGACY,
    CSEI_SPACE_CONFIG,
    CSEI_SPACE_CARDBUS,
    CSEI_SPACE_NONE
  } csei_space_t;

  localparam logic [7:0] OFS_CHANGE_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CHANGE_ENABLES = 8'h05;
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h1E;
  localparam logic [7:0] OFS_FUNC_STATUS = 8'h91;
  localparam logic [7:0] OFS_ROUTE = 8'hA0;
  localparam logic [7:0] OFS_CB_EVENT = 8'h00;
  localparam logic [7:0] OFS_CB_ENABLE = 8'h04;

  localparam int BIT_BATTERY_ONE = 0;
  localparam int BIT_BATTERY_TWO = 1;
  localparam int BIT_READY = 2;
  localparam int BIT_POWER_DONE = 3;
  localparam int BIT_CB_STATUS = 0;
  localparam int BIT_CB_DETECT_A = 1;
  localparam int BIT_CB_DETECT_B = 2;
  localparam int BIT_FLAG_CLEAR_SELECT = 2;
  localparam int BIT_FUNC_PENDING = 0;

  localparam int ROUTE_STATUS_LSB = 0;
  localparam int ROUTE_FUNC_LSB = 4;
  localparam int ROUTE_SERIAL = 8;

  localparam int PIN_COUNT = 7;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  localparam logic [2:0] STATUS_PIN_RESET = 3'h0;
  localparam logic [2:0] FUNC_PIN_RESET = 3'h1;
endpackage

// file: core/csei_top.sv
// Socket event detection, flag and mask registers, and host interrupt pin drive.
// Card pins are asynchronous and active high here; card type and power-done come
// from socket logic on ref_clk. A serializer outside takes serial_irq_pending_q.
`timescale 1ns/10ps
module csei_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic battery_detect_one,
  input wire logic battery_detect_two,
  input wire logic card_ready_request,
  input wire logic card_detect_a,
  input wire logic card_detect_b,
  input wire csei_pkg::csei_card_t card_type,
  input wire logic power_cycle_done,
  input wire csei_pkg::csei_space_t reg_space,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic [csei_pkg::PIN_COUNT-1:0] multifunction_pins_q,
  output logic serial_irq_pending_q
);
  // Two-stage synchronisers for the five card pins
  logic [4:0] pins_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  assign pins_raw = {card_detect_b, card_detect_a, card_ready_request,
                     battery_detect_two, battery_detect_one};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic [4:0] toggled;
  logic [4:0] rose;
  assign toggled = sync2_q ^ prev_q;
  assign rose = sync2_q & ~prev_q;

  logic is_memory;
  logic is_io;
  logic is_cardbus;
  assign is_memory = (card_type == csei_pkg::CSEI_CARD_MEMORY);
  assign is_io = (card_type == csei_pkg::CSEI_CARD_IO);
  assign is_cardbus = (card_type == csei_pkg::CSEI_CARD_CARDBUS);

  // Event sources per card type
  logic [3:0] legacy_set;
  logic [3:0] cb_set;
  logic func_pending;
  always_comb begin
    legacy_set = 4'h0;
    cb_set = 4'h0;
    legacy_set[csei_pkg::BIT_BATTERY_ONE] = (is_memory & toggled[0]) |
                                            (is_io & rose[0]);
    legacy_set[csei_pkg::BIT_BATTERY_TWO] = is_memory & toggled[1];
    legacy_set[csei_pkg::BIT_READY] = is_memory & toggled[2];
    legacy_set[csei_pkg::BIT_POWER_DONE] = (is_memory | is_io) & power_cycle_done;
    cb_set[csei_pkg::BIT_CB_STATUS] = is_cardbus & rose[0];
    cb_set[csei_pkg::BIT_CB_DETECT_A] = toggled[3];
    cb_set[csei_pkg::BIT_CB_DETECT_B] = toggled[4];
    cb_set[csei_pkg::BIT_POWER_DONE] = is_cardbus & power_cycle_done;
  end
  assign func_pending = (is_io | is_cardbus) & sync2_q[2];

  // Register state
  logic [3:0] legacy_flags_q;
  logic [3:0] legacy_flags_d;
  logic [3:0] legacy_en_q;
  logic [3:0] legacy_en_d;
  logic [3:0] cb_event_q;
  logic [3:0] cb_event_d;
  logic [3:0] cb_en_q;
  logic [3:0] cb_en_d;
  logic flag_clear_select_q;
  logic flag_clear_select_d;
  logic [2:0] status_pin_q;
  logic [2:0] status_pin_d;
  logic [2:0] func_pin_q;
  logic [2:0] func_pin_d;
  logic serial_mode_q;
  logic serial_mode_d;
  logic [31:0] reg_rdata_d;
  logic [csei_pkg::PIN_COUNT-1:0] pins_d;
  logic serial_irq_pending_d;
  logic status_irq;

  logic hit_flags;
  logic hit_enables;
  logic hit_global;
  logic hit_func;
  logic hit_route;
  logic hit_cb_event;
  logic hit_cb_enable;
  assign hit_flags = (reg_space == csei_pkg::CSEI_SPACE_LEGACY) &&
                     (reg_addr == csei_pkg::OFS_CHANGE_FLAGS);
  assign hit_enables = (reg_space == csei_pkg::CSEI_SPACE_LEGACY) &&
                       (reg_addr == csei_pkg::OFS_CHANGE_ENABLES);
  assign hit_global = (reg_space == csei_pkg::CSEI_SPACE_LEGACY) &&
                      (reg_addr == csei_pkg::OFS_GLOBAL_CONTROL);
  assign hit_func = (reg_space == csei_pkg::CSEI_SPACE_CONFIG) &&
                    (reg_addr == csei_pkg::OFS_FUNC_STATUS);
  assign hit_route = (reg_space == csei_pkg::CSEI_SPACE_CONFIG) &&
                     (reg_addr == csei_pkg::OFS_ROUTE);
  assign hit_cb_event = (reg_space == csei_pkg::CSEI_SPACE_CARDBUS) &&
                        (reg_addr == csei_pkg::OFS_CB_EVENT);
  assign hit_cb_enable = (reg_space == csei_pkg::CSEI_SPACE_CARDBUS) &&
                         (reg_addr == csei_pkg::OFS_CB_ENABLE);

  assign status_irq = (|(legacy_flags_q & legacy_en_q)) | (|(cb_event_q & cb_en_q));

  always_comb begin
    logic [3:0] legacy_clr;
    logic [3:0] cb_clr;
    legacy_clr = 4'h0;
    cb_clr = 4'h0;
    // Clear-on-read when select is low, write-one-to-clear when high
    if (hit_flags && reg_rd && !flag_clear_select_q) begin
      legacy_clr = 4'hF;
    end
    if (hit_flags && reg_wr && flag_clear_select_q) begin
      legacy_clr = reg_wdata[3:0];
    end
    if (hit_cb_event && reg_wr) begin
      cb_clr = reg_wdata[3:0];
    end
    // A new event in the clearing cycle survives
    legacy_flags_d = (legacy_flags_q & ~legacy_clr) | legacy_set;
    cb_event_d = (cb_event_q & ~cb_clr) | cb_set;

    legacy_en_d = legacy_en_q;
    cb_en_d = cb_en_q;
    flag_clear_select_d = flag_clear_select_q;
    status_pin_d = status_pin_q;
    func_pin_d = func_pin_q;
    serial_mode_d = serial_mode_q;
    if (reg_wr) begin
      if (hit_enables) begin
        legacy_en_d = reg_wdata[3:0];
      end
      if (hit_cb_enable) begin
        cb_en_d = reg_wdata[3:0];
      end
      if (hit_global) begin
        flag_clear_select_d = reg_wdata[csei_pkg::BIT_FLAG_CLEAR_SELECT];
      end
      if (hit_route) begin
        status_pin_d = reg_wdata[csei_pkg::ROUTE_STATUS_LSB +: 3];
        func_pin_d = reg_wdata[csei_pkg::ROUTE_FUNC_LSB +: 3];
        serial_mode_d = reg_wdata[csei_pkg::ROUTE_SERIAL];
      end
    end

    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = 32'h0000_0000;
      if (hit_flags) begin
        reg_rdata_d[3:0] = legacy_flags_q;
      end
      if (hit_enables) begin
        reg_rdata_d[3:0] = legacy_en_q;
      end
      if (hit_global) begin
        reg_rdata_d[csei_pkg::BIT_FLAG_CLEAR_SELECT] = flag_clear_select_q;
      end
      if (hit_func) begin
        reg_rdata_d[csei_pkg::BIT_FUNC_PENDING] = func_pending;
      end
      if (hit_route) begin
        reg_rdata_d[csei_pkg::ROUTE_STATUS_LSB +: 3] = status_pin_q;
        reg_rdata_d[csei_pkg::ROUTE_FUNC_LSB +: 3] = func_pin_q;
        reg_rdata_d[csei_pkg::ROUTE_SERIAL] = serial_mode_q;
      end
      if (hit_cb_event) begin
        reg_rdata_d[3:0] = cb_event_q;
      end
      if (hit_cb_enable) begin
        reg_rdata_d[3:0] = cb_en_q;
      end
    end

    // Status-change interrupt always on its PCI-style pin; functional request on
    // its pin in parallel mode, or to the serializer in serial mode
    for (int i = 0; i < csei_pkg::PIN_COUNT; i++) begin
      pins_d[i] = (status_irq && (status_pin_q == 3'(i))) ||
                  (func_pending && !serial_mode_q && (func_pin_q == 3'(i)));
    end
    serial_irq_pending_d = func_pending && serial_mode_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      legacy_flags_q <= csei_pkg::FLAGS_RESET;
      legacy_en_q <= csei_pkg::ENABLES_RESET;
      cb_event_q <= csei_pkg::FLAGS_RESET;
      cb_en_q <= csei_pkg::ENABLES_RESET;
      flag_clear_select_q <= 1'b0;
      status_pin_q <= csei_pkg::STATUS_PIN_RESET;
      func_pin_q <= csei_pkg::FUNC_PIN_RESET;
      serial_mode_q <= 1'b0;
      reg_rdata_q <= 32'h0000_0000;
      multifunction_pins_q <= '0;
      serial_irq_pending_q <= 1'b0;
    end else begin
      legacy_flags_q <= legacy_flags_d;
      legacy_en_q <= legacy_en_d;
      cb_event_q <= cb_event_d;
      cb_en_q <= cb_en_d;
      flag_clear_select_q <= flag_clear_select_d;
      status_pin_q <= status_pin_d;
      func_pin_q <= func_pin_d;
      serial_mode_q <= serial_mode_d;
      reg_rdata_q <= reg_rdata_d;
      multifunction_pins_q <= pins_d;
      serial_irq_pending_q <= serial_irq_pending_d;
    end
  end

  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_battery_sets_flag: assert property (
    is_memory && toggled[1] |=> legacy_flags_q[csei_pkg::BIT_BATTERY_TWO])
    else $error("battery change did not set flag");
  a_ready_memory_only: assert property (
    is_memory |-> !func_pending)
    else $error("memory card ready treated as request");
  a_io_status_rise: assert property (
    is_io && rose[0] |=> legacy_flags_q[csei_pkg::BIT_BATTERY_ONE])
    else $error("io status change lost");
  a_power_done_route: assert property (
    is_cardbus && power_cycle_done |=> cb_event_q[3] && !$rose(legacy_flags_q[3]))
    else $error("cardbus power done misrouted");
  a_detect_any_type: assert property (
    toggled[3] |=> cb_event_q[csei_pkg::BIT_CB_DETECT_A])
    else $error("detect change not flagged");
  a_read_clears: assert property (
    hit_flags && reg_rd && !flag_clear_select_q && legacy_set == 4'h0 |=>
      legacy_flags_q == 4'h0)
    else $error("clear on read failed");
  a_w1c_keeps_rest: assert property (
    hit_cb_event && reg_wr && cb_set == 4'h0 |=>
      cb_event_q == ($past(cb_event_q) & ~$past(reg_wdata[3:0])))
    else $error("cardbus write one clear wrong");
  a_func_status_read: assert property (
    hit_func && reg_rd |=> reg_rdata_q[0] == $past(func_pending))
    else $error("functional status misread");
  a_irq_follows_flags: assert property (
    status_irq && status_pin_q == 3'h0 |=> multifunction_pins_q[0])
    else $error("status-change interrupt not driven");
  a_irq_drops: assert property (
    !status_irq && !func_pending ##1 !status_irq |-> multifunction_pins_q == '0)
    else $error("interrupt pin stuck");
  a_battery_one_flag: assert property (
    is_memory && toggled[0] |=> legacy_flags_q[csei_pkg::BIT_BATTERY_ONE])
    else $error("battery one change did not set flag");
  a_legacy_set_wins: assert property (
    legacy_set != 4'h0 |=> (legacy_flags_q & $past(legacy_set)) == $past(legacy_set))
    else $error("legacy event lost against a clear");
  a_ready_sets_flag: assert property (
    is_memory && toggled[2] |=> legacy_flags_q[csei_pkg::BIT_READY])
    else $error("ready change did not set flag");
  a_power_legacy: assert property (
    (is_memory || is_io) && power_cycle_done |=> legacy_flags_q[csei_pkg::BIT_POWER_DONE])
    else $error("power done not flagged for 16-bit card");
  a_cb_status_rise: assert property (
    is_cardbus && rose[0] |=> cb_event_q[csei_pkg::BIT_CB_STATUS])
    else $error("cardbus status change lost");
  a_detect_b_flag: assert property (
    toggled[4] |=> cb_event_q[csei_pkg::BIT_CB_DETECT_B])
    else $error("second detect change not flagged");
  a_cb_set_wins: assert property (
    cb_set != 4'h0 |=> (cb_event_q & $past(cb_set)) == $past(cb_set))
    else $error("cardbus event lost against a clear");
  a_func_pin_drive: assert property (
    func_pending && !serial_mode_q && func_pin_q == 3'h1 |=> multifunction_pins_q[1])
    else $error("functional request not on its pin");
  a_serial_request: assert property (
    func_pending && serial_mode_q |=> serial_irq_pending_q)
    else $error("serial request not raised");
  a_serial_idle: assert property (
    !serial_mode_q |=> !serial_irq_pending_q)
    else $error("serial request raised in parallel mode");
  a_w1c_legacy: assert property (
    hit_flags && reg_wr && flag_clear_select_q && legacy_set == 4'h0 |=>
      legacy_flags_q == ($past(legacy_flags_q) & ~$past(reg_wdata[3:0])))
    else $error("legacy write one clear wrong");
  a_read_keeps_w1c: assert property (
    hit_flags && reg_rd && !reg_wr && flag_clear_select_q |=>
      (legacy_flags_q & $past(legacy_flags_q)) == $past(legacy_flags_q))
    else $error("read cleared flags in write one mode");
  a_legacy_sticky: assert property (
    !(hit_flags && (reg_rd || reg_wr)) |=>
      (legacy_flags_q & $past(legacy_flags_q)) == $past(legacy_flags_q))
    else $error("legacy flag lost without access");
  a_cb_sticky: assert property (
    !(hit_cb_event && reg_wr) |=> (cb_event_q & $past(cb_event_q)) == $past(cb_event_q))
    else $error("cardbus flag lost without write");
  a_pins_quiet: assert property (
    !status_irq && !func_pending |=> multifunction_pins_q == '0)
    else $error("interrupt pin raised with nothing pending");
endmodule

// file: verif/csei_card_model.sv
// Behavioural card sitting in the socket; drives the five card pins.
// Assumes the bench updates the requested pin levels on the falling edge of ref_clk.
`timescale 1ns/10ps
module csei_card_model (
  input wire logic ref_clk,
  input wire logic [4:0] want,
  output logic battery_detect_one,
  output logic battery_detect_two,
  output logic card_ready_request,
  output logic card_detect_a,
  output logic card_detect_b
);
  logic [4:0] lvl;
  assign {battery_detect_one, battery_detect_two, card_ready_request} = lvl[4:2];
  assign {card_detect_a, card_detect_b} = lvl[1:0];
  initial lvl = 5'h00;
  // Pins move on the rising edge after the request, never racing the bench
  always @(posedge ref_clk) begin
    lvl <= want;
  end
endmodule

// file: verif/tb.sv
// Self-checking bench for the socket event interrupt block.
// Assumes csei_pkg is compiled first; the card model drives all card pins.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam csei_pkg::csei_space_t LG = csei_pkg::CSEI_SPACE_LEGACY;
  localparam csei_pkg::csei_space_t CF = csei_pkg::CSEI_SPACE_CONFIG;
  localparam csei_pkg::csei_space_t CB = csei_pkg::CSEI_SPACE_CARDBUS;
  logic ref_clk, reset_n, power_cycle_done, reg_wr, reg_rd, serial_irq_pending_q;
  logic battery_detect_one, battery_detect_two, card_ready_request;
  logic card_detect_a, card_detect_b;
  csei_pkg::csei_card_t card_type;
  csei_pkg::csei_space_t reg_space;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q;
  logic [6:0] multifunction_pins_q;
  logic [4:0] want;
  int n_errors, checks_done;
  csei_card_model i_card (.ref_clk, .want, .battery_detect_one, .battery_detect_two,
    .card_ready_request, .card_detect_a, .card_detect_b);
  csei_top i_dut (.ref_clk, .reset_n, .battery_detect_one, .battery_detect_two,
    .card_ready_request, .card_detect_a, .card_detect_b, .card_type, .power_cycle_done,
    .reg_space, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
    .multifunction_pins_q, .serial_irq_pending_q);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task settle;
    repeat (6) @(negedge ref_clk);
  endtask
  task wr(input csei_pkg::csei_space_t s, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_space = s;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task rd(input csei_pkg::csei_space_t s, input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    reg_space = s;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    `CHK("rdata", e, reg_rdata_q)
  endtask
  task card(input logic [4:0] w);
    @(negedge ref_clk);
    want = w;
    settle();
  endtask
  task pwr;
    @(negedge ref_clk);
    power_cycle_done = 1'b1;
    @(negedge ref_clk);
    power_cycle_done = 1'b0;
    settle();
  endtask
  // Bounded wait for the interrupt pins to reach a level
  task pins_are(input logic [6:0] e);
    int i;
    i = 0;
    while (multifunction_pins_q !== e && i < 10) begin
      @(negedge ref_clk);
      i++;
    end
    if (multifunction_pins_q !== e) begin
      n_errors++;
      $display("BAD pins wait exp %0h got %0h", e, multifunction_pins_q);
      end_of_test();
    end else begin
      `CHK("pins", e, multifunction_pins_q)
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("BAD watchdog expired");
    end_of_test();
  end
  initial begin
    {reset_n, power_cycle_done, reg_wr, reg_rd} = 4'h0;
    card_type = csei_pkg::CSEI_CARD_NONE;
    reg_space = LG;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    want = 5'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    rd(LG, 8'h04, 32'h0);
    rd(LG, 8'h05, 32'h0);
    rd(CB, 8'h00, 32'h0);
    rd(CF, 8'hA0, 32'h10);
    rd(csei_pkg::CSEI_SPACE_NONE, 8'h04, 32'h0);
    // Detect pins with an empty socket, then write-one clears
    card(5'h02);
    card(5'h03);
    rd(CB, 8'h00, 32'h6);
    wr(CB, 8'h00, 32'h2);
    rd(CB, 8'h00, 32'h4);
    wr(CB, 8'h00, 32'h4);
    // Memory card: battery and ready changes, no functional request
    card_type = csei_pkg::CSEI_CARD_MEMORY;
    wr(LG, 8'h05, 32'h1);
    card(5'h13);
    pins_are(7'h01);
    card(5'h1B);
    card(5'h1F);
    rd(CF, 8'h91, 32'h0);
    rd(LG, 8'h04, 32'h7);
    rd(LG, 8'h04, 32'h0);
    pins_are(7'h00);
    // I/O card: request is unmasked, status change acts on assertion only
    card_type = csei_pkg::CSEI_CARD_IO;
    pins_are(7'h02);
    rd(CF, 8'h91, 32'h1);
    card(5'h0F);
    rd(LG, 8'h04, 32'h0);
    card(5'h1F);
    pins_are(7'h03);
    wr(LG, 8'h1E, 32'h4);
    rd(LG, 8'h1E, 32'h4);
    rd(LG, 8'h04, 32'h1);
    pwr();
    rd(LG, 8'h04, 32'h9);
    wr(LG, 8'h04, 32'h9);
    rd(LG, 8'h04, 32'h0);
    card(5'h1B);
    pins_are(7'h00);
    // CardBus card with the functional request sent serially
    card_type = csei_pkg::CSEI_CARD_CARDBUS;
    wr(CB, 8'h04, 32'h1);
    rd(CB, 8'h04, 32'h1);
    wr(CF, 8'hA0, 32'h110);
    rd(CF, 8'hA0, 32'h110);
    card(5'h0B);
    card(5'h1B);
    pins_are(7'h01);
    pwr();
    rd(CB, 8'h00, 32'h9);
    card(5'h1F);
    `CHK("serial", 1'b1, serial_irq_pending_q)
    `CHK("pins", 7'h01, multifunction_pins_q)
    wr(CB, 8'h00, 32'h9);
    card(5'h1B);
    pins_are(7'h00);
    `CHK("serial", 1'b0, serial_irq_pending_q)
    end_of_test();
  end
endmodule
